// ### common/mle_defines.vh
`ifndef MLE_DEFINES_VH
`define MLE_DEFINES_VH

// address table geometry
`define MLE_TBL_AW 10
`define MLE_TBL_LAST 10'h3ff
`define MLE_ENTRY_W 52
// entry fields: address, time stamp, port, valid
`define MLE_E_ADDR_HI 47
`define MLE_E_STAMP 48
`define MLE_E_PORT_HI 50
`define MLE_E_PORT_LO 49
`define MLE_E_VALID 51
// group (multicast) bit of a station address, first octet lsb
`define MLE_GROUP_BIT 40
`define MLE_BCAST_ADDR 48'hffffffffffff

// ports
`define MLE_NPORT 3
`define MLE_ALL_PORTS 3'h7

// configuration register 3, aging enable bit
`define MLE_CFG3_AGING_BIT 2

// frame length limits in bytes
`define MLE_MIN_LEN 11'h040
`define MLE_MAX_LEN_0 11'h5ee
`define MLE_MAX_LEN_1 11'h600
`define MLE_MAX_LEN_2 11'h77c
`define MLE_VLAN_ADJ 11'h004

// frame buffer pool: 256 buffers of 128 bytes, 32kB
`define MLE_NUM_BUF 256
`define MLE_BUF_AW 8
`define MLE_BUF_BYTES 128
`define MLE_BUF_CNT_W 9
`define MLE_BUF_CNT_RST 9'h100

// timing
`define MLE_CLK_HZ 10000000
`define MLE_AGE_PERIOD_S 200
// the sweep runs every half period, so a stale entry goes in 100..200 s
`define MLE_AGE_HALF_CYC ((`MLE_AGE_PERIOD_S / 2) * `MLE_CLK_HZ)

`endif

// ### core/mle_table_mem.v
`timescale 1ns/1ps
`include "mle_defines.vh"

module mle_table_mem #(
  parameter AW = `MLE_TBL_AW,
  parameter DW = `MLE_ENTRY_W
) (
  // clock
  input wire clk,
  // read port, data one cycle after address
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_q,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule

// ### core/mle_engine.v
// Overview of operation
// - 1K entries, linear table, every unicast address learnable
// - learn only absent source of good frame
// - new entry holds address, ingress port, stamp
// - table full: reuse last entry slot
// - good frame on new port migrates entry
// - any source match refreshes time stamp
// - background aging removes stale entries, ~200 s
// - aging enabled by config register 3 bit 2
// - stage one: vlan, static, dynamic destination search
// - stage two: stp, snooping, mirror
// - never forward errored or illegal-size frames
// - pause frames consumed, drive flow control
// - destination equals ingress port: local, discard
// - whole frame stored before forwarding decision
// - 32kB pool, 256 buffers of 128 bytes
// - legal length 64 to programmed maximum
`timescale 1ns/1ps
`include "mle_defines.vh"

module mle_engine #(
  parameter AW = `MLE_TBL_AW,
  parameter [31:0] AGE_TICK_CYC = `MLE_AGE_HALF_CYC
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // received frame descriptor, offered after the frame is fully stored
  input wire frm_valid,
  output wire frm_ready,
  input wire [47:0] frm_source_station_address,
  input wire [47:0] frm_destination_station_address,
  input wire [1:0] frm_port,
  input wire [10:0] frm_len,
  input wire frm_err,
  input wire frm_vlan_tagged,
  input wire frm_pause,
  input wire [15:0] frm_pause_time,
  input wire [`MLE_BUF_AW-1:0] frm_head_buf,
  // configuration
  input wire [7:0] cfg_global_ctrl3,
  input wire [1:0] cfg_max_len_sel,
  input wire [2:0] vlan_member_mask,
  input wire static_valid,
  input wire [47:0] static_addr,
  input wire [2:0] static_mask,
  input wire [2:0] stp_fwd_mask,
  input wire [2:0] snoop_mask,
  input wire mirror_en,
  input wire [2:0] mirror_mask,
  // forwarding decision
  output reg dec_valid_q,
  output reg [2:0] dec_first_stage_port_mask_q,
  output reg [2:0] dec_final_port_mask_q,
  output reg dec_drop_q,
  output reg dec_local_q,
  output reg [`MLE_BUF_AW-1:0] dec_head_buf_q,
  // flow control from received pause frames
  output reg pause_valid_q,
  output reg [1:0] pause_port_q,
  output reg [15:0] pause_time_q,
  // frame buffer allocation
  input wire buf_alloc_req,
  output wire buf_alloc_gnt,
  output reg [`MLE_BUF_AW-1:0] buf_alloc_id_q,
  input wire buf_free_req,
  input wire [`MLE_BUF_AW-1:0] buf_free_id,
  output reg [`MLE_BUF_CNT_W-1:0] buf_free_cnt_q
);

  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SCAN = 3'h2;
  localparam [2:0] ST_UPD = 3'h3;
  localparam [2:0] ST_AGE = 3'h4;
  localparam DW = `MLE_ENTRY_W;
  localparam [AW-1:0] LAST = {AW{1'b1}};

  reg [2:0] st_q;
  reg [AW:0] idx_q;
  reg cmp_v_q;
  reg [AW-1:0] cmp_idx_q;
  reg [47:0] sa_q;
  reg [47:0] da_q;
  reg [1:0] port_q;
  reg [10:0] len_q;
  reg err_q;
  reg tag_q;
  reg pause_q;
  reg [15:0] ptime_q;
  reg [`MLE_BUF_AW-1:0] head_q;
  reg sa_hit_q;
  reg [AW-1:0] sa_idx_q;
  reg [1:0] sa_port_q;
  reg da_hit_q;
  reg [1:0] da_port_q;
  reg empty_found_q;
  reg [AW-1:0] empty_idx_q;
  reg [31:0] age_cnt_q;
  reg age_pend_q;

  wire [DW-1:0] rd_data;
  reg wr_en;
  reg [AW-1:0] wr_addr;
  reg [DW-1:0] wr_data;

  wire e_valid = rd_data[`MLE_E_VALID];
  wire e_stamp = rd_data[`MLE_E_STAMP];
  wire [1:0] e_port = rd_data[`MLE_E_PORT_HI:`MLE_E_PORT_LO];
  wire [47:0] e_addr = rd_data[`MLE_E_ADDR_HI:0];
  wire issuing = ((st_q == ST_SCAN) || (st_q == ST_AGE)) && !idx_q[AW];
  wire last_cmp = cmp_v_q && (cmp_idx_q == LAST);
  wire aging_en = cfg_global_ctrl3[`MLE_CFG3_AGING_BIT];

  ////////////////////////////////////////////////////////////////////////
  // address table: searched linearly, so no slot is lost to collisions

  mle_table_mem #(.AW(AW), .DW(DW)) u_table (
    .clk(clk),
    .rd_addr(idx_q[AW-1:0]),
    .rd_data_q(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame qualification and forwarding decision

  reg [10:0] max_len;
  reg len_ok;
  reg good;
  reg learn_ok;
  reg [2:0] in_mask;
  reg st_hit;
  reg da_group;
  reg [2:0] fs_mask;
  reg [2:0] fin_mask;
  reg local_frm;

  always @* begin
    case (cfg_max_len_sel)
      2'h0: max_len = `MLE_MAX_LEN_0;
      2'h1: max_len = `MLE_MAX_LEN_1;
      default: max_len = `MLE_MAX_LEN_2;
    endcase
    if (tag_q) begin
      max_len = max_len + `MLE_VLAN_ADJ;
    end
    len_ok = (len_q >= `MLE_MIN_LEN) && (len_q <= max_len);
    good = !err_q && len_ok;
    // group source addresses are never learned into a unicast table
    learn_ok = good && !sa_q[`MLE_GROUP_BIT];
    in_mask = 3'h1 << port_q;
    da_group = da_q[`MLE_GROUP_BIT];
    st_hit = static_valid && (da_q == static_addr);
    if (st_hit) begin
      fs_mask = static_mask;
    end else if (da_hit_q && !da_group) begin
      fs_mask = 3'h1 << da_port_q;
    end else begin
      fs_mask = `MLE_ALL_PORTS;
    end
    fs_mask = fs_mask & vlan_member_mask;
    fin_mask = fs_mask & stp_fwd_mask;
    if (da_group && (da_q != `MLE_BCAST_ADDR) && !st_hit) begin
      fin_mask = fin_mask & snoop_mask;
    end
    fin_mask = fin_mask & ~in_mask;
    if (mirror_en) begin
      fin_mask = fin_mask | (mirror_mask & ~in_mask);
    end
    local_frm = !st_hit && da_hit_q && !da_group &&
      (da_port_q == port_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // table write port

  always @* begin
    wr_en = 1'b0;
    wr_addr = cmp_idx_q;
    wr_data = {DW{1'b0}};
    case (st_q)
      ST_INIT: begin
        wr_en = 1'b1;
        wr_addr = idx_q[AW-1:0];
      end
      ST_AGE: begin
        if (cmp_v_q && e_valid) begin
          wr_en = 1'b1;
          // seen since last sweep: clear the stamp, otherwise remove
          if (e_stamp) begin
            wr_data = {1'b1, e_port, 1'b0, e_addr};
          end
        end
      end
      ST_UPD: begin
        if (sa_hit_q) begin
          wr_en = 1'b1;
          wr_addr = sa_idx_q;
          // errored frames refresh the stamp but never move a station
          wr_data = {1'b1, (learn_ok ? port_q : sa_port_q), 1'b1,
            sa_q};
        end else if (learn_ok) begin
          wr_en = 1'b1;
          wr_addr = empty_found_q ? empty_idx_q : LAST;
          wr_data = {1'b1, port_q, 1'b1, sa_q};
        end
      end
      default: begin
        wr_en = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // lookup, learning and aging sequencer

  // a frame is only taken once it is completely in the buffers
  assign frm_ready = (st_q == ST_IDLE) && !age_pend_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_INIT;
      idx_q <= {(AW+1){1'b0}};
      cmp_v_q <= 1'b0;
      cmp_idx_q <= {AW{1'b0}};
      sa_q <= 48'h0;
      da_q <= 48'h0;
      port_q <= 2'h0;
      len_q <= 11'h0;
      err_q <= 1'b0;
      tag_q <= 1'b0;
      pause_q <= 1'b0;
      ptime_q <= 16'h0;
      head_q <= {`MLE_BUF_AW{1'b0}};
      sa_hit_q <= 1'b0;
      sa_idx_q <= {AW{1'b0}};
      sa_port_q <= 2'h0;
      da_hit_q <= 1'b0;
      da_port_q <= 2'h0;
      empty_found_q <= 1'b0;
      empty_idx_q <= {AW{1'b0}};
      age_cnt_q <= 32'h0;
      age_pend_q <= 1'b0;
      dec_valid_q <= 1'b0;
      dec_first_stage_port_mask_q <= 3'h0;
      dec_final_port_mask_q <= 3'h0;
      dec_drop_q <= 1'b0;
      dec_local_q <= 1'b0;
      dec_head_buf_q <= {`MLE_BUF_AW{1'b0}};
      pause_valid_q <= 1'b0;
      pause_port_q <= 2'h0;
      pause_time_q <= 16'h0;
    end else begin
      dec_valid_q <= 1'b0;
      pause_valid_q <= 1'b0;
      cmp_v_q <= issuing;
      cmp_idx_q <= idx_q[AW-1:0];
      if (issuing) begin
        idx_q <= idx_q + 1'b1;
      end
      case (st_q)
        ST_INIT: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q[AW-1:0] == LAST) begin
            idx_q <= {(AW+1){1'b0}};
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          idx_q <= {(AW+1){1'b0}};
          if (frm_valid && frm_ready) begin
            sa_q <= frm_source_station_address;
            da_q <= frm_destination_station_address;
            port_q <= frm_port;
            len_q <= frm_len;
            err_q <= frm_err;
            tag_q <= frm_vlan_tagged;
            pause_q <= frm_pause;
            ptime_q <= frm_pause_time;
            head_q <= frm_head_buf;
            sa_hit_q <= 1'b0;
            da_hit_q <= 1'b0;
            empty_found_q <= 1'b0;
            st_q <= ST_SCAN;
          end else if (age_pend_q) begin
            st_q <= ST_AGE;
          end
        end
        ST_SCAN: begin
          if (cmp_v_q && e_valid && (e_addr == sa_q)) begin
            sa_hit_q <= 1'b1;
            sa_idx_q <= cmp_idx_q;
            sa_port_q <= e_port;
          end
          if (cmp_v_q && e_valid && (e_addr == da_q)) begin
            da_hit_q <= 1'b1;
            da_port_q <= e_port;
          end
          if (cmp_v_q && !e_valid && !empty_found_q) begin
            empty_found_q <= 1'b1;
            empty_idx_q <= cmp_idx_q;
          end
          if (last_cmp) begin
            st_q <= ST_UPD;
          end
        end
        ST_UPD: begin
          dec_valid_q <= 1'b1;
          dec_first_stage_port_mask_q <= fs_mask;
          dec_final_port_mask_q <= fin_mask;
          dec_drop_q <= !good || pause_q || local_frm ||
            (fin_mask == 3'h0);
          dec_local_q <= local_frm;
          dec_head_buf_q <= head_q;
          pause_valid_q <= pause_q && good;
          pause_port_q <= port_q;
          pause_time_q <= ptime_q;
          st_q <= ST_IDLE;
        end
        ST_AGE: begin
          if (last_cmp) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_INIT;
        end
      endcase
      // background aging tick; a tick landing as a sweep starts still counts
      if (st_q == ST_IDLE && !(frm_valid && frm_ready) && age_pend_q) begin
        age_pend_q <= 1'b0;
      end
      if (!aging_en) begin
        age_cnt_q <= 32'h0;
      end else if (age_cnt_q >= AGE_TICK_CYC - 32'h1) begin
        age_cnt_q <= 32'h0;
        age_pend_q <= 1'b1;
      end else begin
        age_cnt_q <= age_cnt_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared buffer pool, one bit per 128-byte buffer

  reg [`MLE_NUM_BUF-1:0] used_q;
  wire ptr_busy = used_q[buf_alloc_id_q];
  wire freeing = buf_free_req && used_q[buf_free_id];

  assign buf_alloc_gnt = buf_alloc_req && !ptr_busy;

  // one buffer per cycle; the pointer walks past used slots one at a time,
  // so a nearly full pool may take up to 256 cycles to grant
  always @(posedge clk) begin
    if (sys_rst) begin
      used_q <= {`MLE_NUM_BUF{1'b0}};
      buf_alloc_id_q <= {`MLE_BUF_AW{1'b0}};
      buf_free_cnt_q <= `MLE_BUF_CNT_RST;
    end else begin
      if (freeing) begin
        used_q[buf_free_id] <= 1'b0;
      end
      if (buf_alloc_gnt) begin
        used_q[buf_alloc_id_q] <= 1'b1;
      end
      if (buf_alloc_gnt || ptr_busy) begin
        buf_alloc_id_q <= buf_alloc_id_q + 1'b1;
      end
      if (freeing && !buf_alloc_gnt) begin
        buf_free_cnt_q <= buf_free_cnt_q + 1'b1;
      end else if (buf_alloc_gnt && !freeing) begin
        buf_free_cnt_q <= buf_free_cnt_q - 1'b1;
      end
    end
  end

endmodule

// ### tb/mle_engine_checker.sv
`timescale 1ns/1ps
module mle_engine_checker #(
  parameter AW = 10
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // descriptor side
  input wire frm_valid,
  input wire frm_ready,
  input wire [1:0] frm_port,
  input wire [10:0] frm_len,
  input wire frm_err,
  input wire frm_pause,
  input wire mirror_en,
  // decision side
  input wire dec_valid_q,
  input wire [2:0] dec_final_port_mask_q,
  input wire dec_drop_q,
  input wire pause_valid_q,
  // buffer pool
  input wire buf_alloc_req,
  input wire buf_alloc_gnt,
  input wire buf_free_req,
  input wire [8:0] buf_free_cnt_q
);
  // taking edge, 2^AW issue edges, last compare, update edge, then sampled
  localparam int LAT = (1 << AW) + 3;
  wire take = frm_valid && frm_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  a_dec_latency: assert property (take |-> ##LAT dec_valid_q)
    else $error("decision not on time");
  a_busy_refuse: assert property (take |=> !frm_ready)
    else $error("second descriptor accepted while busy");
  a_dec_pulse: assert property (dec_valid_q |=> !dec_valid_q)
    else $error("decision pulse too long");
  a_err_drop: assert property (take && frm_err |-> ##LAT dec_drop_q)
    else $error("errored frame forwarded");
  a_short_drop: assert property (take && frm_len < 11'h040 |->
    ##LAT dec_drop_q)
    else $error("short frame forwarded");
  a_pause_eaten: assert property (take && frm_pause && !frm_err &&
    frm_len >= 11'h040 && frm_len <= 11'h5ee |->
    ##LAT (pause_valid_q && dec_drop_q))
    else $error("pause frame not consumed");
  a_pause_pair: assert property (pause_valid_q |-> dec_valid_q)
    else $error("pause report without decision");
  a_no_ingress: assert property (take && !mirror_en |->
    ##LAT (dec_drop_q ||
    (dec_final_port_mask_q & (3'h1 << $past(frm_port, LAT))) == 3'h0))
    else $error("frame sent back to ingress port");
  a_alloc_count: assert property (buf_alloc_req && buf_alloc_gnt &&
    !buf_free_req |=> buf_free_cnt_q == $past(buf_free_cnt_q) - 9'h001)
    else $error("free count not decremented");
  a_empty_refuse: assert property (buf_free_cnt_q == 9'h000 |->
    !buf_alloc_gnt)
    else $error("grant from empty pool");
  a_reset_pool: assert property ($fell(sys_rst) |->
    buf_free_cnt_q == 9'h100 && !frm_ready)
    else $error("bad state after reset");
  c_drop: cover property (dec_valid_q && dec_drop_q);
  c_pause: cover property (pause_valid_q);
  c_full: cover property (buf_alloc_req && !buf_alloc_gnt);
endmodule

// ### tb/mle_mac_model.sv
`timescale 1ns/1ps
module mle_mac_model (
  // clock and handshake
  input wire clk,
  input wire frm_ready,
  output reg frm_valid,
  // descriptor fields
  output reg [47:0] frm_source_station_address,
  output reg [47:0] frm_destination_station_address,
  output reg [1:0] frm_port,
  output reg [10:0] frm_len,
  output reg frm_err,
  output reg frm_vlan_tagged,
  output reg frm_pause,
  output reg [15:0] frm_pause_time,
  output reg [7:0] frm_head_buf
);
  initial begin
    frm_valid = 1'b0;
    frm_source_station_address = 48'h0;
    frm_destination_station_address = 48'h0;
    {frm_port, frm_len, frm_err, frm_vlan_tagged} = 15'h0;
    {frm_pause, frm_pause_time, frm_head_buf} = 25'h0;
  end
  // called at a falling edge; holds the offer until an edge takes it
  task send(input [47:0] sa, input [47:0] da, input [1:0] p,
    input [10:0] len, input e, input tg, input ps);
    integer n;
    begin
      frm_source_station_address = sa;
      frm_destination_station_address = da;
      {frm_port, frm_len, frm_err, frm_vlan_tagged} = {p, len, e, tg};
      {frm_pause, frm_pause_time, frm_head_buf} = {ps, da[15:0], sa[7:0]};
      frm_valid = 1'b1;
      n = 0;
      while (frm_ready !== 1'b1 && n < 500) begin
        @(negedge clk);
        n = n + 1;
      end
      @(negedge clk);
      // released addresses change so stale values are never reused
      frm_valid = 1'b0;
      frm_source_station_address = ~sa;
      frm_destination_station_address = ~da;
    end
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam [47:0] SA = 48'h02000000000a, SB = 48'h02000000000b;
  localparam [47:0] SC = 48'h02000000000c, SD = 48'h02000000000d;
  localparam [47:0] SF = 48'h02000000000f, SG = 48'h020000000010;
  localparam [47:0] UK = 48'h02000000ff00, SS = 48'h02000000005e;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] cfg_global_ctrl3 = 8'h04;
  reg [1:0] cfg_max_len_sel = 2'h0;
  reg [2:0] vlan_member_mask = 3'h7, stp_fwd_mask = 3'h7;
  reg [2:0] snoop_mask = 3'h7, static_mask = 3'h4, mirror_mask = 3'h1;
  reg static_valid = 1'b0, mirror_en = 1'b0;
  reg buf_alloc_req = 1'b0, buf_free_req = 1'b0;
  reg [7:0] buf_free_id = 8'h00;
  wire frm_valid, frm_ready, frm_err, frm_vlan_tagged, frm_pause;
  wire [47:0] frm_source_station_address, frm_destination_station_address;
  wire [1:0] frm_port, pause_port_q;
  wire [10:0] frm_len;
  wire [15:0] frm_pause_time, pause_time_q;
  wire [7:0] frm_head_buf, dec_head_buf_q;
  wire [2:0] dec_first_stage_port_mask_q, dec_final_port_mask_q;
  wire dec_valid_q, dec_drop_q, dec_local_q, pause_valid_q, buf_alloc_gnt;
  wire [8:0] buf_free_cnt_q;
  integer error_cnt = 0;
  integer n_tests = 0;
  always #50 clk = ~clk;
  mle_mac_model mle_mac_model_inst (.clk(clk), .frm_ready(frm_ready),
    .frm_valid(frm_valid), .frm_port(frm_port), .frm_len(frm_len),
    .frm_source_station_address(frm_source_station_address),
    .frm_destination_station_address(frm_destination_station_address),
    .frm_err(frm_err), .frm_vlan_tagged(frm_vlan_tagged),
    .frm_pause(frm_pause), .frm_pause_time(frm_pause_time),
    .frm_head_buf(frm_head_buf));
  mle_engine #(.AW(4), .AGE_TICK_CYC(32'd3000)) mle_engine_inst (
    .clk(clk), .sys_rst(sys_rst), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm_port(frm_port), .frm_len(frm_len),
    .frm_source_station_address(frm_source_station_address),
    .frm_destination_station_address(frm_destination_station_address),
    .frm_err(frm_err), .frm_vlan_tagged(frm_vlan_tagged),
    .frm_pause(frm_pause), .frm_pause_time(frm_pause_time),
    .frm_head_buf(frm_head_buf), .cfg_global_ctrl3(cfg_global_ctrl3),
    .cfg_max_len_sel(cfg_max_len_sel), .vlan_member_mask(vlan_member_mask),
    .static_valid(static_valid), .static_addr(SS),
    .static_mask(static_mask), .stp_fwd_mask(stp_fwd_mask),
    .snoop_mask(snoop_mask), .mirror_en(mirror_en),
    .mirror_mask(mirror_mask), .dec_valid_q(dec_valid_q),
    .dec_first_stage_port_mask_q(dec_first_stage_port_mask_q),
    .dec_final_port_mask_q(dec_final_port_mask_q),
    .dec_drop_q(dec_drop_q), .dec_local_q(dec_local_q),
    .dec_head_buf_q(dec_head_buf_q), .pause_valid_q(pause_valid_q),
    .pause_port_q(pause_port_q), .pause_time_q(pause_time_q),
    .buf_alloc_req(buf_alloc_req), .buf_alloc_gnt(buf_alloc_gnt),
    .buf_alloc_id_q(), .buf_free_req(buf_free_req),
    .buf_free_id(buf_free_id), .buf_free_cnt_q(buf_free_cnt_q));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] got, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task frame(input [47:0] s, input [47:0] d, input [1:0] p,
    input [10:0] len, input e, input tg, input ps);
    integer n;
    begin
      mle_mac_model_inst.send(s, d, p, len, e, tg, ps);
      n = 0;
      while (dec_valid_q !== 1'b1 && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(dec_valid_q, 1'b1);
    end
  endtask
  task len_case(input [1:0] sel, input [10:0] len, input tg, input exp);
    begin
      cfg_max_len_sel = sel;
      frame(SB, SA, 2'd1, len, 1'b0, tg, 1'b0);
      chk(dec_drop_q, exp);
    end
  endtask
  task t_learn_local;
    begin
      frame(SA, UK, 2'd0, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_first_stage_port_mask_q, 3'h7);
      chk(dec_final_port_mask_q, 3'h6);
      chk(dec_head_buf_q, SA[7:0]);
      frame(SB, SA, 2'd1, 11'd100, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h1);
      frame(SC, SA, 2'd0, 11'd100, 1'b0, 1'b0, 1'b0);
      chk({dec_drop_q, dec_local_q}, 2'h3);
      frame(SA, UK, 2'd2, 11'd64, 1'b0, 1'b0, 1'b0);
      frame(SB, SA, 2'd1, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h4);
    end
  endtask
  task t_errors;
    begin
      frame(SD, SA, 2'd0, 11'd64, 1'b1, 1'b0, 1'b0);
      chk(dec_drop_q, 1'b1);
      frame(SB, SD, 2'd1, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h5);
      len_case(2'd0, 11'd63, 1'b0, 1'b1);
      len_case(2'd0, 11'd64, 1'b0, 1'b0);
      len_case(2'd0, 11'd1519, 1'b0, 1'b1);
      len_case(2'd0, 11'd1522, 1'b1, 1'b0);
      len_case(2'd1, 11'd1537, 1'b0, 1'b1);
      len_case(2'd2, 11'd1916, 1'b0, 1'b0);
      len_case(2'd2, 11'd1917, 1'b0, 1'b1);
      cfg_max_len_sel = 2'd0;
      frame(SC, 48'h0180c2000001, 2'd2, 11'd64, 1'b0, 1'b0, 1'b1);
      chk({dec_drop_q, pause_valid_q, pause_port_q}, 4'he);
      chk(pause_time_q, 16'h0001);
    end
  endtask
  task t_stage_two;
    begin
      vlan_member_mask = 3'h5;
      frame(SF, UK, 2'd0, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_first_stage_port_mask_q, 3'h5);
      vlan_member_mask = 3'h7;
      stp_fwd_mask = 3'h3;
      frame(SF, UK, 2'd0, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h2);
      stp_fwd_mask = 3'h7;
      static_valid = 1'b1;
      frame(SG, SS, 2'd1, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_first_stage_port_mask_q, 3'h4);
      mirror_en = 1'b1;
      frame(SG, SS, 2'd1, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h5);
      mirror_en = 1'b0;
    end
  endtask
  task t_buffers;
    integer i, g;
    begin
      g = 0;
      buf_alloc_req = 1'b1;
      // let the combinational grant settle before the first look
      #1;
      for (i = 0; i < 300; i = i + 1) begin
        if (buf_alloc_gnt === 1'b1)
          g = g + 1;
        @(negedge clk);
      end
      chk(g, 256);
      chk(buf_free_cnt_q, 9'h000);
      buf_alloc_req = 1'b0;
      buf_free_req = 1'b1;
      for (i = 0; i < 256; i = i + 1) begin
        buf_free_id = i[7:0];
        @(negedge clk);
      end
      buf_free_req = 1'b0;
      @(negedge clk);
      chk(buf_free_cnt_q, 9'h100);
    end
  endtask
  // sweep every 3000 cycles; an entry goes on the second sweep unrefreshed
  task t_aging;
    begin
      cfg_global_ctrl3 = 8'h00;
      frame(SC, UK, 2'd2, 11'd64, 1'b0, 1'b0, 1'b0);
      repeat (6200) @(negedge clk);
      frame(SB, SC, 2'd1, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h4);
      cfg_global_ctrl3 = 8'h04;
      repeat (4000) @(negedge clk);
      frame(SC, UK, 2'd2, 11'd64, 1'b0, 1'b0, 1'b0);
      repeat (2200) @(negedge clk);
      frame(SB, SC, 2'd1, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h4);
      repeat (3000) @(negedge clk);
      frame(SB, SC, 2'd1, 11'd64, 1'b0, 1'b0, 1'b0);
      chk(dec_final_port_mask_q, 3'h5);
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(buf_free_cnt_q, 9'h100);
    t_learn_local;
    t_errors;
    t_stage_two;
    t_buffers;
    t_aging;
    finish_test;
  end
  initial begin
    #4000000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule
bind mle_engine mle_engine_checker #(.AW(AW)) mle_engine_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .frm_valid(frm_valid),
  .frm_ready(frm_ready), .frm_port(frm_port), .frm_len(frm_len),
  .frm_err(frm_err), .frm_pause(frm_pause), .mirror_en(mirror_en),
  .dec_valid_q(dec_valid_q), .dec_final_port_mask_q(dec_final_port_mask_q),
  .dec_drop_q(dec_drop_q), .pause_valid_q(pause_valid_q),
  .buf_alloc_req(buf_alloc_req), .buf_alloc_gnt(buf_alloc_gnt),
  .buf_free_req(buf_free_req), .buf_free_cnt_q(buf_free_cnt_q));
